/* File: hw/sdl_defs.svh */
// Timing and width constants for the serial DAC input loader
`ifndef SDL_DEFS_SVH
`define SDL_DEFS_SVH

`define SDL_CODE_W 8
`define SDL_BITS_PER_FRAME 4'h8
`define SDL_CODE_RESET 8'h00
`define SDL_BUF_DEPTH 2
`define SDL_SCLK_MAX_MHZ 50

`endif

/* File: hw/sdl_loader.sv */
// Serial DAC input loader: shift register, code buffer and DAC latch
//
// Contract
// R1 - Sample serial data on each serial clock falling edge during a frame.
// R2 - The input register is exactly eight bits, one code per frame.
// R3 - Frame sync low enables shifting; frame sync high disables it.
// R4 - Host gives eight falling edges per frame; device takes eight bits.
// R5 - Falling edge of load input copies input register into DAC latch; code copies the oldest buffered code when the buffer is not empty.
// R6 - Load held low: latch loads after eight edges with frame sync low.
// R7 - Host keeps serial clock at or below 50 MHz.
// R8 - Latch code is straight unsigned binary, zero to 255.
// R9 - Reset clears shift register and DAC latch to zero.
// R10 - Code arrives MSB first, shifted in at the LSB end.
`include "sdl_defs.svh"
module sdl_loader
  import sdl_pkg::*;
#(
  parameter int CODE_W = `SDL_CODE_W
)
(
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic ARST_N_I,
  // Serial link from host
  input wire logic SERIAL_CLOCK_I,
  input wire logic FRAME_SYNC_N_I,
  input wire logic SERIAL_DATA_IN_I,
  input wire logic LOAD_OUTPUT_N_I,
  // DAC latch code, unsigned binary
  output logic [CODE_W-1:0] DAC_CODE_O,
  output logic DAC_UPDATE_O,
  // Input register view and buffer state
  output logic [CODE_W-1:0] INPUT_CODE_O,
  output logic BUF_FULL_O
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  logic sclk_prev;
  logic load_prev;

  always_ff @(posedge CLOCK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      sync_a <= 4'hf;
      sync_b <= 4'hf;
      sclk_prev <= 1'b1;
      load_prev <= 1'b1;
    end
    else
    begin
      sync_a <= {LOAD_OUTPUT_N_I, SERIAL_DATA_IN_I, FRAME_SYNC_N_I,
                 SERIAL_CLOCK_I};
      sync_b <= sync_a;
      sclk_prev <= sync_b[0];
      load_prev <= sync_b[3];
    end
  end

  logic sclk_s;
  logic fsync_n_s;
  logic sdata_s;
  logic load_n_s;
  logic sclk_fall;
  logic load_fall;

  always_comb
  begin
    sclk_s = sync_b[0];
    fsync_n_s = sync_b[1];
    sdata_s = sync_b[2];
    load_n_s = sync_b[3];
    sclk_fall = sclk_prev && !sclk_s;
    load_fall = load_prev && !load_n_s;
  end

  // ****************************************
  // Frame shifter
  // ****************************************
  sdl_state_type state;
  sdl_state_type next_state;
  logic [CODE_W-1:0] shift_reg;
  logic [CODE_W-1:0] next_shift_reg;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic frame_done;
  logic buf_in_ready;

  always_comb
  begin
    next_state = state;
    next_shift_reg = shift_reg;
    next_bit_cnt = bit_cnt;
    frame_done = 1'b0;
    unique case (state)
      SDL_IDLE:
      begin
        // R3 enable on sync
        if (fsync_n_s)
          next_bit_cnt = 4'h0;
        // R4 one frame per sync
        else if (bit_cnt == 4'h0)
          next_state = SDL_SHIFT;
      end
      SDL_SHIFT:
      begin
        // R3 abort on sync high
        if (fsync_n_s)
          next_state = SDL_IDLE;
        // R1 R10 sample MSB first
        else if (sclk_fall)
        begin
          next_shift_reg = {shift_reg[CODE_W-2:0], sdata_s};
          next_bit_cnt = bit_cnt + 4'h1;
          // R4 R2 eight bits
          if (bit_cnt == `SDL_BITS_PER_FRAME - 4'h1)
            next_state = SDL_DONE;
        end
      end
      SDL_DONE:
      begin
        // Stall here if the buffer is full, so this word is kept; frames sent while stalled are dropped
        if (buf_in_ready)
        begin
          frame_done = 1'b1;
          // Count stays at eight until sync rises
          next_state = SDL_IDLE;
        end
      end
    endcase
  end

  // ****************************************
  // Two-entry code buffer
  // ****************************************
  logic [CODE_W-1:0] buf_mem [`SDL_BUF_DEPTH];
  logic [CODE_W-1:0] next_buf_mem [`SDL_BUF_DEPTH];
  logic [1:0] buf_cnt;
  logic [1:0] next_buf_cnt;
  logic buf_out_valid;
  logic buf_pop;
  logic [CODE_W-1:0] input_code;
  logic [CODE_W-1:0] next_input_code;
  logic [CODE_W-1:0] dac_code;
  logic [CODE_W-1:0] next_dac_code;
  logic dac_update;
  logic next_dac_update;
  logic load_req;
  logic buf_full;
  logic next_buf_full;

  always_comb
  begin
    buf_in_ready = (buf_cnt != 2'h2);
    buf_out_valid = (buf_cnt != 2'h0);
    // R6 auto update when load held low
    load_req = load_fall || (!load_n_s && !load_prev);
    buf_pop = buf_out_valid && load_req;
    next_buf_mem = buf_mem;
    next_buf_cnt = buf_cnt;
    if (buf_pop)
    begin
      next_buf_mem[0] = buf_mem[1];
      next_buf_cnt = next_buf_cnt - 2'h1;
    end
    if (frame_done)
    begin
      next_buf_mem[next_buf_cnt[0]] = shift_reg;
      next_buf_cnt = next_buf_cnt + 2'h1;
    end
    next_buf_full = (next_buf_cnt == 2'h2);
    next_input_code = frame_done ? shift_reg : input_code;
    next_dac_code = dac_code;
    next_dac_update = 1'b0;
    // R5 R8 latch code on load
    if (buf_pop)
    begin
      next_dac_code = buf_mem[0];
      next_dac_update = 1'b1;
    end
    else if (load_fall)
    begin
      next_dac_code = input_code;
      next_dac_update = 1'b1;
    end
  end

  // ****************************************
  // State registers
  // ****************************************
  always_ff @(posedge CLOCK_I or negedge ARST_N_I)
  begin
    // R9 clear on reset
    if (!ARST_N_I)
    begin
      state <= SDL_IDLE;
      shift_reg <= `SDL_CODE_RESET;
      bit_cnt <= 4'h0;
      buf_mem <= '{default: `SDL_CODE_RESET};
      buf_cnt <= 2'h0;
      buf_full <= 1'b0;
      input_code <= `SDL_CODE_RESET;
      dac_code <= `SDL_CODE_RESET;
      dac_update <= 1'b0;
    end
    else
    begin
      state <= next_state;
      shift_reg <= next_shift_reg;
      bit_cnt <= next_bit_cnt;
      buf_mem <= next_buf_mem;
      buf_cnt <= next_buf_cnt;
      buf_full <= next_buf_full;
      input_code <= next_input_code;
      dac_code <= next_dac_code;
      dac_update <= next_dac_update;
    end
  end

  always_comb
  begin
    DAC_CODE_O = dac_code;
    DAC_UPDATE_O = dac_update;
    INPUT_CODE_O = input_code;
    BUF_FULL_O = buf_full;
  end

endmodule

/* File: hw/sdl_pkg.sv */
// Types shared by the serial DAC input loader
`include "sdl_defs.svh"
package sdl_pkg;
  typedef logic [`SDL_CODE_W-1:0] sdl_code_type;
  typedef enum logic [1:0] {SDL_IDLE, SDL_SHIFT, SDL_DONE} sdl_state_type;
endpackage

/* File: verification/sdl_host.sv */
// Host model that drives frames on the serial link
module sdl_host
  import sdl_pkg::*;
(
  // Serial link
  output logic sclk_o = 1'h1,
  output logic sync_n_o = 1'h1,
  output logic data_o = 1'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  // MSB first, 160 ns clock, idle high
  task automatic send(input sdl_code_type c, input int n);
    #3 sync_n_o = 1'h0;
    for (int i = 7; i > 7 - n; i--)
    begin
      data_o = c[i];
      #80 sclk_o = 1'h0;
      #80 sclk_o = 1'h1;
    end
    sync_n_o = 1'h1;
    data_o = ~data_o;
  endtask
endmodule

/* File: verification/sdl_loader_bench.sv */
// Self-checking bench for the serial DAC input loader
module sdl_loader_bench import sdl_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic ld_n = 1'h1;
  logic sck, syn_n, sd, upd, full;
  sdl_code_type dac, inp, code;
  int bad_count = 0;
  int checked = 0;
  int seed = 32'h37086128;
  always #5 clk = ~clk;
  sdl_host i_sdl_host (.sclk_o(sck), .sync_n_o(syn_n), .data_o(sd));
  sdl_loader i_sdl_loader (.CLOCK_I(clk), .ARST_N_I(rst_n),
    .SERIAL_CLOCK_I(sck), .FRAME_SYNC_N_I(syn_n), .SERIAL_DATA_IN_I(sd),
    .LOAD_OUTPUT_N_I(ld_n), .DAC_CODE_O(dac), .DAC_UPDATE_O(upd),
    .INPUT_CODE_O(inp), .BUF_FULL_O(full));
  task automatic check(input sdl_code_type got, want);
    checked++;
    if (got !== want)
    begin
      bad_count++;
      $display("Error %0t: %h not %h", $time, got, want);
    end
  endtask
  task automatic stop_test;
    $display("%0d bad of %0d", bad_count, checked);
    if (bad_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic frame(input sdl_code_type c, input int n);
    i_sdl_host.send(c, n);
    repeat (8) @(negedge clk);
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    repeat (4) @(negedge clk);
    check(inp, 8'h00);
    check(dac, 8'h00);
    @(posedge clk);
    ld_n <= 1'h0;
    for (int i = 0; i < 12; i++)
    begin
      code = i == 0 ? 8'hff : i == 1 ? 8'h00 : 8'($random(seed));
      frame(code, 8);
      check(inp, code);
      check(dac, code);
    end
    frame(8'h5a, 4);
    check(inp, code);
    @(posedge clk);
    ld_n <= 1'h1;
    frame(8'h3c, 8);
    frame(8'hc3, 8);
    check({7'h00, full}, 8'h01);
    check(dac, code);
    @(posedge clk);
    ld_n <= 1'h0;
    repeat (8) @(negedge clk);
    check(dac, 8'hc3);
    stop_test();
  end
endmodule
bind sdl_loader sdl_loader_monitor #(.CODE_W(CODE_W)) i_mon (.CLOCK_I,
  .ARST_N_I, .FRAME_SYNC_N_I, .SERIAL_DATA_IN_I, .LOAD_OUTPUT_N_I,
  .DAC_CODE_O, .DAC_UPDATE_O, .INPUT_CODE_O);

/* File: verification/sdl_loader_monitor.sv */
// Port assertions for the serial DAC input loader
module sdl_loader_monitor #(parameter int CODE_W = 8)
(
  // Watched ports
  input wire logic CLOCK_I,
  input wire logic ARST_N_I,
  input wire logic FRAME_SYNC_N_I,
  input wire logic SERIAL_DATA_IN_I,
  input wire logic LOAD_OUTPUT_N_I,
  input wire logic [CODE_W-1:0] DAC_CODE_O,
  input wire logic DAC_UPDATE_O,
  input wire logic [CODE_W-1:0] INPUT_CODE_O
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!ARST_N_I);
  sequence s_new; $changed(INPUT_CODE_O); endsequence
  property p_rst; $rose(ARST_N_I) |-> DAC_CODE_O == '0; endproperty
  property p_hold; !DAC_UPDATE_O |-> $stable(DAC_CODE_O); endproperty
  property p_sync; s_new |-> !$past(FRAME_SYNC_N_I, 4); endproperty
  property p_lsb;
    s_new |-> INPUT_CODE_O[0] == $past(SERIAL_DATA_IN_I, 4);
  endproperty
  property p_bit1;
    s_new |-> INPUT_CODE_O[1] == $past(SERIAL_DATA_IN_I, 20);
  endproperty
  property p_bit2;
    s_new |-> INPUT_CODE_O[2] == $past(SERIAL_DATA_IN_I, 36);
  endproperty
  property p_auto;
    s_new ##0 !LOAD_OUTPUT_N_I && !$past(LOAD_OUTPUT_N_I, 6)
      |-> ##[1:2] DAC_UPDATE_O && DAC_CODE_O == INPUT_CODE_O;
  endproperty
  property p_fall; $fell(LOAD_OUTPUT_N_I) |-> ##[2:5] DAC_UPDATE_O; endproperty
  a_rst: assert property (p_rst) else $error("reset");
  a_hold: assert property (p_hold) else $error("hold");
  a_sync: assert property (p_sync) else $error("sync");
  a_lsb: assert property (p_lsb) else $error("bit0");
  a_bit1: assert property (p_bit1) else $error("bit1");
  a_bit2: assert property (p_bit2) else $error("bit2");
  a_auto: assert property (p_auto) else $error("auto");
  a_fall: assert property (p_fall) else $error("load");
endmodule
